// [tap_pkg.sv]
// shared constants, types and cell decoding for the boundary scan port
package tap_pkg;

  localparam int CHAIN_LEN = 120;
  localparam int ID_LEN = 32;
  // chain index of the lowest identification cell (position 89)
  localparam int ID_LOW_IDX = 88;
  localparam int IR_W = 3;
  localparam int SYNC_DEPTH = 2;

  localparam logic [IR_W-1:0] OP_EXTEST = 3'h0;
  localparam logic [IR_W-1:0] OP_IDCODE = 3'h1;
  localparam logic [IR_W-1:0] OP_SAMPLE = 3'h2;
  localparam logic [IR_W-1:0] OP_SINGLE_CHAIN = 3'h3;
  localparam logic [IR_W-1:0] OP_BYPASS = 3'h7;
  // fixed pattern loaded in capture-ir, low two bits 01
  localparam logic [IR_W-1:0] IR_CAPTURE_VALUE = 3'h1;
  localparam logic [IR_W-1:0] IR_RESET_VALUE = OP_IDCODE;

  // fixed capture bits of cells below the identification field
  localparam logic [ID_LOW_IDX-1:0] FIXED_LOW_BITS = 88'h0000_0001_c000_0009_2492_7f;

  localparam logic [1:0] KIND_IN = 2'h0;
  localparam logic [1:0] KIND_OUT = 2'h1;
  localparam logic [1:0] KIND_IO = 2'h2;

  typedef enum logic [15:0] {
    ST_RESET = 16'h0001,
    ST_IDLE = 16'h0002,
    ST_SEL_DR = 16'h0004,
    ST_CAP_DR = 16'h0008,
    ST_SHIFT_DR = 16'h0010,
    ST_EXIT1_DR = 16'h0020,
    ST_PAUSE_DR = 16'h0040,
    ST_EXIT2_DR = 16'h0080,
    ST_UPD_DR = 16'h0100,
    ST_SEL_IR = 16'h0200,
    ST_CAP_IR = 16'h0400,
    ST_SHIFT_IR = 16'h0800,
    ST_EXIT1_IR = 16'h1000,
    ST_PAUSE_IR = 16'h2000,
    ST_EXIT2_IR = 16'h4000,
    ST_UPD_IR = 16'h8000
  } tap_state_e;

  typedef enum logic [1:0] {
    PATH_BYPASS = 2'h0,
    PATH_ID = 2'h1,
    PATH_CHAIN = 2'h2
  } path_e;

  // cell type by chain position 1..120
  function automatic logic [1:0] cell_kind(input int pos);
    if (pos == 120) return KIND_OUT;
    if (pos >= 112) return KIND_IN;
    if (pos >= 96) return KIND_OUT;
    if (pos >= 87) return KIND_IN;
    if (pos == 86) return KIND_OUT;
    if (pos >= 70) return (pos % 2 == 1) ? KIND_IO : KIND_OUT;
    if (pos >= 55) return KIND_IN;
    if (pos >= 31) return KIND_OUT;
    if (pos >= 7) begin
      if ((pos - 7) % 3 == 0) return KIND_IN;
      if ((pos - 7) % 3 == 2) return KIND_IO;
      return KIND_OUT;
    end
    return KIND_IN;
  endfunction

  // outputs floated by the global tristate cell
  function automatic logic tristate_controlled(input int pos);
    return (pos >= 96 && pos <= 111) || pos == 86 || (pos >= 31 && pos <= 54);
  endfunction

  // unassigned opcodes fall back to bypass
  function automatic path_e decode_path(input logic [IR_W-1:0] op);
    case (op)
      OP_EXTEST, OP_SAMPLE, OP_SINGLE_CHAIN: return PATH_CHAIN;
      OP_IDCODE: return PATH_ID;
      default: return PATH_BYPASS;
    endcase
  endfunction

endpackage

// [tap_ctrl_if.sv]
// controller timing and state shared between the scan modules
`timescale 1ns/1ps
interface tap_ctrl_if;
  import tap_pkg::*;
  logic tck_rise;
  logic tck_fall;
  logic data_reg_gated_clock;
  tap_state_e state;

  modport ctrl (
    output tck_rise,
    output tck_fall,
    output data_reg_gated_clock,
    output state
  );
  modport user (
    input tck_rise,
    input tck_fall,
    input data_reg_gated_clock,
    input state
  );
endinterface

// [tap_state_machine.sv]
// sixteen-state test access controller stepped on rising test clock edges
`timescale 1ns/1ps
module tap_state_machine import tap_pkg::*; (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic test_reset,
  input wire logic tck_s,
  input wire logic tms_s,
  tap_ctrl_if.ctrl ctl
);

  logic tck_d_r;
  tap_state_e state_r;
  tap_state_e state_nxt;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tck_d_r <= 1'b0;
    end else begin
      tck_d_r <= tck_s;
    end
  end

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_RESET: state_nxt = tms_s ? ST_RESET : ST_IDLE;
      ST_IDLE: state_nxt = tms_s ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: state_nxt = tms_s ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: state_nxt = tms_s ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: state_nxt = tms_s ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: state_nxt = tms_s ? ST_UPD_DR : ST_PAUSE_DR;
      ST_PAUSE_DR: state_nxt = tms_s ? ST_EXIT2_DR : ST_PAUSE_DR; // [R3]
      ST_EXIT2_DR: state_nxt = tms_s ? ST_UPD_DR : ST_SHIFT_DR;
      ST_UPD_DR: state_nxt = tms_s ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: state_nxt = tms_s ? ST_RESET : ST_CAP_IR;
      ST_CAP_IR: state_nxt = tms_s ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: state_nxt = tms_s ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: state_nxt = tms_s ? ST_UPD_IR : ST_PAUSE_IR;
      ST_PAUSE_IR: state_nxt = tms_s ? ST_EXIT2_IR : ST_PAUSE_IR; // [R3]
      ST_EXIT2_IR: state_nxt = tms_s ? ST_UPD_IR : ST_SHIFT_IR;
      ST_UPD_IR: state_nxt = tms_s ? ST_SEL_DR : ST_IDLE;
      default: state_nxt = ST_RESET;
    endcase
  end

  // five high tms samples reach reset from any state by the graph itself
  always_ff @(posedge sys_clk) begin
    if (rst || test_reset) begin
      state_r <= ST_RESET; // [R20]
    end else if (tck_s && !tck_d_r) begin
      state_r <= state_nxt; // [R20]
    end
  end

  assign ctl.tck_rise = tck_s && !tck_d_r;
  assign ctl.tck_fall = !tck_s && tck_d_r;
  assign ctl.state = state_r;
  // only moves in shift-dr or capture-dr
  assign ctl.data_reg_gated_clock = ctl.tck_rise &&
    (state_r == ST_SHIFT_DR || state_r == ST_CAP_DR); // [R18]

endmodule

// [boundary_chain.sv]
// boundary cells: four-way capture mux, shift stage and update latch
`timescale 1ns/1ps
module boundary_chain import tap_pkg::*; #(
  parameter int LEN = CHAIN_LEN
) (
  input wire logic sys_clk,
  input wire logic rst,
  tap_ctrl_if.user ctl,
  input wire logic tdi_s,
  input wire logic chain_selected,
  input wire logic id_capture,
  input wire logic [LEN-1:0] pin_value,
  input wire logic [LEN-1:0] id_value,
  output logic [LEN-1:0] shift_q,
  output logic [LEN-1:0] update_q
);

  // serial path needs at least a two-cell chain
  if (LEN < 2) begin : g_bad_len
    $error("boundary chain shorter than two cells");
  end

  logic cell_mux_select_a;
  logic cell_mux_select_b;
  logic [LEN-1:0] serial_in;

  // 00 hold, 01 serial, 10 pin, 11 fixed id bit
  assign cell_mux_select_a = ctl.state == ST_CAP_DR; // [R19]
  assign cell_mux_select_b = (ctl.state == ST_SHIFT_DR) ||
    (ctl.state == ST_CAP_DR && id_capture); // [R19]
  // serial data enters at the top cell nearest tdi
  assign serial_in = {tdi_s, shift_q[LEN-1:1]}; // [R17] [R21]

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      shift_q <= '0;
    end else if (ctl.data_reg_gated_clock && chain_selected) begin // [R18]
      for (int i = 0; i < LEN; i++) begin
        unique case ({cell_mux_select_a, cell_mux_select_b})
          2'b00: shift_q[i] <= shift_q[i]; // [R3]
          2'b01: shift_q[i] <= serial_in[i]; // [R21]
          2'b10: shift_q[i] <= pin_value[i]; // [R6] [R8] [R22]
          2'b11: shift_q[i] <= id_value[i]; // [R10] [R13]
        endcase
      end
    end
  end

  // reset leaves every enable cell low, so extest right after reset drives
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      update_q <= '0;
    end else if (ctl.tck_fall && ctl.state == ST_UPD_DR && chain_selected) begin
      update_q <= shift_q; // [R7] [R22]
    end
  end

endmodule

// [boundary_scan_tap.sv]
// How it works
// [R1] update-ir loads instruction on test clock fall
// [R2] controller shifts instruction before passing update-ir
// [R3] pause states hold shift path contents
// [R4] each instruction selects exactly one tdi-tdo path
// [R5] bypass gives one test clock delay
// [R6] extest captures input pins into chain
// [R7] extest drives outputs from update latches
// [R8] sample captures pins without altering them
// [R9] identification instruction shifts out the code
// [R10] single chain test captures fixed id bits
// [R11] 120 cells: input, output, bidirectional
// [R12] positions 120 to 89 hold identification code
// [R13] lower cells also hold fixed capture bits
// [R14] positions 120 to 117 hold revision
// [R15] low enable cell makes bidirectional pin output
// [R16] global tristate cell high floats listed outputs
// [R17] global tristate cell is first, nearest tdi
// [R18] cell clock moves only in shift/capture-dr
// [R19] cell four-way mux steered by two selects
// [R20] test reset or five tms highs reset
// [R21] shifting one stage per rise, msb to lsb
// [R22] capture on rise, update latches on fall
// [R23] all-ones and unassigned opcodes act as bypass
`timescale 1ns/1ps
module boundary_scan_tap import tap_pkg::*; #(
  // identification body and revision: arbitrary values, lsb kept at one
  parameter logic [3:0] REVISION = 4'h2,
  parameter logic [27:0] IDENT_BODY = 28'h5a3_c1e5
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic test_reset_n,
  output logic tdo,
  output logic tdo_oe_n,
  input wire logic [CHAIN_LEN-1:0] core_value,
  input wire logic [CHAIN_LEN-1:0] pad_in,
  output logic [CHAIN_LEN-1:0] pad_out,
  output logic [CHAIN_LEN-1:0] pad_oe_n
);

  localparam logic [ID_LEN-1:0] ID_CODE = {REVISION, IDENT_BODY}; // [R14]

  // the per-cell wiring below is written for exactly this layout; the code lsb must be one
  if (CHAIN_LEN != 120 || ID_LOW_IDX + ID_LEN != CHAIN_LEN ||
      IDENT_BODY[0] != 1'b1) begin : g_bad_layout
    $error("chain layout does not match cell map");
  end

  tap_ctrl_if ctl ();

  logic [SYNC_DEPTH-1:0] tck_sync_r;
  logic [SYNC_DEPTH-1:0] tms_sync_r;
  logic [SYNC_DEPTH-1:0] tdi_sync_r;
  logic [SYNC_DEPTH-1:0] trst_sync_r;
  logic [CHAIN_LEN-1:0] pad_meta_r;
  logic [CHAIN_LEN-1:0] pad_in_r;
  logic [IR_W-1:0] ir_shift_r;
  logic [IR_W-1:0] ir_active_r;
  logic bypass_r;
  path_e path;
  logic ext_test;
  logic id_capture;
  logic [CHAIN_LEN-1:0] chain_q;
  logic [CHAIN_LEN-1:0] update_q;
  logic [CHAIN_LEN-1:0] drive_value;
  logic [CHAIN_LEN-1:0] capture_value;
  logic [CHAIN_LEN-1:0] id_value;
  logic [CHAIN_LEN-1:0] oe_n_nxt;
  logic tdo_nxt;

  // every test pin crosses into sys_clk through two flops
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tck_sync_r <= '0;
      tms_sync_r <= '1;
      tdi_sync_r <= '1;
      trst_sync_r <= '0;
    end else begin
      tck_sync_r <= {tck_sync_r[0], tck};
      tms_sync_r <= {tms_sync_r[0], tms};
      tdi_sync_r <= {tdi_sync_r[0], tdi};
      trst_sync_r <= {trst_sync_r[0], test_reset_n};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pad_meta_r <= '0;
      pad_in_r <= '0;
    end else begin
      pad_meta_r <= pad_in;
      pad_in_r <= pad_meta_r;
    end
  end

  // test reset is sampled, so it acts within three sys_clk edges, not at once
  tap_state_machine fsm (
    .sys_clk(sys_clk),
    .rst(rst),
    .test_reset(!trst_sync_r[1]), // [R20]
    .tck_s(tck_sync_r[1]),
    .tms_s(tms_sync_r[1]),
    .ctl(ctl)
  );

  assign path = decode_path(ir_active_r); // [R4] [R23]
  assign ext_test = ir_active_r == OP_EXTEST;
  assign id_capture = ir_active_r == OP_IDCODE || ir_active_r == OP_SINGLE_CHAIN; // [R10] [R13]

  // instruction shift stage, fixed capture pattern
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ir_shift_r <= IR_RESET_VALUE;
    end else if (ctl.tck_rise && ctl.state == ST_CAP_IR) begin
      ir_shift_r <= IR_CAPTURE_VALUE;
    end else if (ctl.tck_rise && ctl.state == ST_SHIFT_IR) begin
      ir_shift_r <= {tdi_sync_r[1], ir_shift_r[IR_W-1:1]}; // [R21]
    end
  end

  // active instruction changes on the fall inside update-ir and reloads IR_RESET_VALUE in test-logic-reset
  always_ff @(posedge sys_clk) begin
    if (rst || ctl.state == ST_RESET) begin
      ir_active_r <= IR_RESET_VALUE; // [R20]
    end else if (ctl.tck_fall && ctl.state == ST_UPD_IR) begin
      ir_active_r <= ir_shift_r; // [R1] [R2]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bypass_r <= 1'b0;
    end else if (ctl.data_reg_gated_clock && path == PATH_BYPASS) begin
      bypass_r <= (ctl.state == ST_SHIFT_DR) ? tdi_sync_r[1] : 1'b0; // [R5]
    end
  end

  // per-cell wiring: drive, capture source, fixed bit and enable
  for (genvar i = 0; i < CHAIN_LEN; i++) begin : g_cell
    localparam int POS = i + 1;
    localparam logic [1:0] KIND = cell_kind(POS); // [R11]
    // normal mode passes the core value; extest forces the latch
    assign drive_value[i] = ext_test ? update_q[i] : core_value[i]; // [R7] [R8]
    if (KIND == KIND_OUT) begin : g_out
      assign capture_value[i] = drive_value[i]; // [R8]
    end else begin : g_in
      assign capture_value[i] = pad_in_r[i]; // [R6] [R8]
    end
    if (i >= ID_LOW_IDX) begin : g_id
      assign id_value[i] = ID_CODE[i-ID_LOW_IDX]; // [R12]
    end else begin : g_fix
      assign id_value[i] = FIXED_LOW_BITS[i]; // [R13]
    end
    if (KIND == KIND_IN) begin : g_oe_in
      assign oe_n_nxt[i] = 1'b1;
    end else if (KIND == KIND_IO) begin : g_oe_io
      // enable cell sits just below its bidirectional pin
      assign oe_n_nxt[i] = drive_value[i-1]; // [R15]
    end else if (tristate_controlled(POS)) begin : g_oe_tri
      assign oe_n_nxt[i] = drive_value[CHAIN_LEN-1]; // [R16] [R17]
    end else begin : g_oe_out
      assign oe_n_nxt[i] = 1'b0;
    end
  end

  boundary_chain #(
    .LEN(CHAIN_LEN)
  ) chain (
    .sys_clk(sys_clk),
    .rst(rst),
    .ctl(ctl),
    .tdi_s(tdi_sync_r[1]),
    .chain_selected(path != PATH_BYPASS), // [R9] [R10]
    .id_capture(id_capture),
    .pin_value(capture_value),
    .id_value(id_value),
    .shift_q(chain_q),
    .update_q(update_q)
  );

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pad_out <= '0;
      pad_oe_n <= '1;
    end else begin
      pad_out <= drive_value;
      pad_oe_n <= oe_n_nxt;
    end
  end

  // identification path is the top 32 cells, so tdo taps position 89
  always_comb begin
    tdo_nxt = bypass_r;
    if (ctl.state == ST_SHIFT_IR) begin
      tdo_nxt = ir_shift_r[0];
    end else begin
      unique case (path)
        PATH_ID: tdo_nxt = chain_q[ID_LOW_IDX]; // [R9] [R12]
        PATH_CHAIN: tdo_nxt = chain_q[0]; // [R6]
        default: tdo_nxt = bypass_r; // [R5]
      endcase
    end
  end

  // tdo changes on the falling test clock edge, driven only while shifting
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tdo <= 1'b0;
      tdo_oe_n <= 1'b1;
    end else if (ctl.tck_fall) begin
      tdo <= tdo_nxt; // [R4]
      tdo_oe_n <= !(ctl.state == ST_SHIFT_DR || ctl.state == ST_SHIFT_IR);
    end
  end

endmodule

// [boundary_scan_tap_asserts.sv]
// concurrent checks on the scan port and pad outputs
`timescale 1ns/1ps
module boundary_scan_tap_asserts import tap_pkg::*; (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic test_reset_n,
  input wire logic tdo,
  input wire logic tdo_oe_n,
  input wire logic [CHAIN_LEN-1:0] core_value,
  input wire logic [CHAIN_LEN-1:0] pad_in,
  input wire logic [CHAIN_LEN-1:0] pad_out,
  input wire logic [CHAIN_LEN-1:0] pad_oe_n
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_rst_outputs_idle: assert property ($past(rst) |-> tdo_oe_n && !tdo && pad_oe_n == '1)
    else $error("outputs not idle after reset");
  a_drive_after_fall: assert property ($fell(tdo_oe_n) |-> !$past(tck, 2))
    else $error("tdo enabled away from a test clock fall");
  a_tdo_after_fall: assert property ($changed(tdo) |-> !$past(tck, 2))
    else $error("tdo moved away from a test clock fall");
  a_tdo_stands: assert property ($rose(tck) |=> $stable(tdo) [*3])
    else $error("tdo moved while test clock high");
  a_inputs_undriven: assert property (pad_oe_n[118:111] == '1 && pad_oe_n[94:86] == '1
    && pad_oe_n[68:54] == '1 && pad_oe_n[5:0] == '1)
    else $error("input cell pad driven");
  a_io_follows_enable: assert property (!$past(rst) |->
    pad_oe_n[84] == pad_out[83] && pad_oe_n[29] == pad_out[28])
    else $error("bidirectional pad ignores its enable cell");
  a_tristate_floats: assert property (!$past(rst) |-> pad_oe_n[110:95] == {16{pad_out[119]}}
    && pad_oe_n[53:30] == {24{pad_out[119]}} && pad_oe_n[85] == pad_out[119])
    else $error("tristate group not following global cell");
  a_outputs_driven: assert property (!$past(rst) |->
    pad_oe_n[119] == 1'b0 && pad_oe_n[83] == 1'b0 && pad_oe_n[69] == 1'b0)
    else $error("plain output pad not driven");
endmodule

bind boundary_scan_tap boundary_scan_tap_asserts boundary_scan_tap_asserts_i (
  .sys_clk(sys_clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi),
  .test_reset_n(test_reset_n), .tdo(tdo), .tdo_oe_n(tdo_oe_n), .core_value(core_value),
  .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n));

// [scan_master_model.sv]
// board scan controller model driving test clock, mode, data and reset pins
`timescale 1ns/1ps
module scan_master_model (
  input wire logic sys_clk,
  input wire logic tdo,
  input wire logic tdo_oe_n,
  output logic tck,
  output logic tms,
  output logic tdi,
  output logic test_reset_n
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    test_reset_n = 1'b1;
  end

  // one test clock period, four system cycles each phase; tdo taken just before the rise
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    repeat (4) @(posedge sys_clk);
    // tdo has no pull, so a released pin reads as the inverse of its last value
    #1 q = tdo_oe_n ? ~tdo : tdo;
    tck = 1'b1;
    repeat (4) @(posedge sys_clk);
    #1 tck = 1'b0;
  endtask

  // held beyond the three sampling cycles the port needs
  task automatic pulse_reset();
    test_reset_n = 1'b0;
    repeat (5) @(posedge sys_clk);
    #1 test_reset_n = 1'b1;
  endtask
endmodule

// [boundary_scan_tap_tb_top.sv]
// self-checking bench for the boundary scan port
`timescale 1ns/1ps
module boundary_scan_tap_tb_top;
  import tap_pkg::*;
  localparam logic [3:0] REV = 4'h2;
  localparam logic [27:0] BODY = 28'h5a3_c1e5;
  localparam logic [119:0] ID_VEC = {88'h0, REV, BODY};
  localparam logic [119:0] ID_MASK = {88'h0, 32'hffff_ffff};
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic tck, tms, tdi, test_reset_n, tdo, tdo_oe_n, q;
  logic [119:0] core_value = '0;
  logic [119:0] pad_in = '0;
  logic [119:0] pad_out, pad_oe_n, pat, got, pin_mask;
  logic [31:0] seed = 32'h45;
  logic [2:0] ops [4] = '{3'h7, 3'h4, 3'h5, 3'h6};
  int n_errors = 0;
  int checks_done = 0;
  int cycles = 0;

  boundary_scan_tap #(.REVISION(REV), .IDENT_BODY(BODY)) boundary_scan_tap_i (
    .sys_clk(sys_clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi),
    .test_reset_n(test_reset_n), .tdo(tdo), .tdo_oe_n(tdo_oe_n), .core_value(core_value),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n));
  scan_master_model scan_master_model_i (.sys_clk(sys_clk), .tdo(tdo), .tdo_oe_n(tdo_oe_n),
    .tck(tck), .tms(tms),
    .tdi(tdi), .test_reset_n(test_reset_n));

  initial begin
    forever #10 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic is_io(input int p);
    return (p >= 71 && p <= 85 && p % 2 == 1) || (p >= 9 && p <= 30 && (p - 7) % 3 == 2);
  endfunction

  // cells whose capture source is the pad rather than the core
  function automatic logic is_pin(input int p);
    return is_io(p) || (p >= 112 && p <= 119) || (p >= 87 && p <= 95) || p <= 6
      || (p >= 55 && p <= 69) || (p >= 7 && p <= 28 && (p - 7) % 3 == 0);
  endfunction

  function automatic logic [119:0] oe_exp(input logic [119:0] v);
    logic [119:0] r;
    for (int p = 1; p <= 120; p++) begin
      if (is_io(p)) r[p-1] = v[p-2];
      else if (is_pin(p)) r[p-1] = 1'b1;
      else r[p-1] = ((p >= 96 && p <= 111) || p == 86 || (p >= 31 && p <= 54)) ? v[119] : 1'b0;
    end
    return r;
  endfunction

  task automatic next_rand(output logic [119:0] v);
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      v = {v[87:0], seed};
    end
  endtask

  task automatic chk_vec(input logic [119:0] g, input logic [119:0] e, input logic [119:0] m);
    checks_done++;
    if (((g ^ e) & m) !== 120'h0) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g & m, e & m);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // from reset or idle through one register scan back to idle; long scans pause at bit 40
  task automatic scan(input logic ir, input int n, input logic [119:0] din,
                      output logic [119:0] dout);
    logic z;
    dout = '0;
    scan_master_model_i.step(1'b0, 1'b0, z);
    scan_master_model_i.step(1'b1, 1'b0, z);
    if (ir) scan_master_model_i.step(1'b1, 1'b0, z);
    scan_master_model_i.step(1'b0, 1'b0, z);
    scan_master_model_i.step(1'b0, 1'b0, z);
    for (int i = 0; i < n; i++) begin
      scan_master_model_i.step(i == n - 1 || (n > 40 && i == 40), din[i], dout[i]);
      if (n > 40 && i == 40) begin
        scan_master_model_i.step(1'b0, ~din[i], z);
        scan_master_model_i.step(1'b0, din[i], z);
        scan_master_model_i.step(1'b1, ~din[i], z);
        scan_master_model_i.step(1'b0, din[i], z);
      end
    end
    scan_master_model_i.step(1'b1, 1'b0, z);
    scan_master_model_i.step(1'b0, 1'b0, z);
    // back in idle the port must have let go of tdo
    chk_vec({119'h0, tdo_oe_n}, {119'h0, 1'b1}, '1);
  endtask

  task automatic load_ir(input logic [2:0] op);
    logic [119:0] cap;
    scan(1'b1, IR_W, {117'h0, op}, cap);
  endtask

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      end_sim();
    end
  end

  initial begin
    for (int p = 1; p <= 120; p++) pin_mask[p-1] = is_pin(p);
    repeat (20) @(posedge sys_clk);
    #1 rst = 1'b0;
    repeat (4) @(posedge sys_clk);
    #1 next_rand(core_value);
    scan(1'b0, 32, '0, got);
    chk_vec(got, ID_VEC, ID_MASK);
    $display("idcode after reset done");
    foreach (ops[j]) begin
      load_ir(ops[j]);
      next_rand(pat);
      scan(1'b0, 40, pat, got);
      chk_vec(got, {pat[118:0], 1'b0}, {80'h0, {40{1'b1}}});
    end
    $display("bypass and unassigned codes done");
    next_rand(pad_in);
    load_ir(OP_SAMPLE);
    next_rand(pat);
    scan(1'b0, 120, pat, got);
    chk_vec(got, (pad_in & pin_mask) | (core_value & ~pin_mask), '1);
    chk_vec(pad_out, core_value, '1);
    $display("sample done");
    for (int h = 0; h < 2; h++) begin
      next_rand(pad_in);
      next_rand(pat);
      pat[119] = h[0];
      load_ir(OP_EXTEST);
      scan(1'b0, 120, pat, got);
      chk_vec(got, pad_in, pin_mask);
      repeat (2) @(posedge sys_clk);
      #1 chk_vec(pad_out, pat, '1);
      chk_vec(pad_oe_n, oe_exp(pat), '1);
    end
    $display("extest done");
    load_ir(OP_SINGLE_CHAIN);
    scan(1'b0, 120, pat, got);
    chk_vec(got, {ID_VEC[31:0], FIXED_LOW_BITS}, '1);
    $display("single chain done");
    load_ir(OP_BYPASS);
    repeat (5) scan_master_model_i.step(1'b1, 1'b0, q);
    scan(1'b0, 32, '0, got);
    chk_vec(got, ID_VEC, ID_MASK);
    load_ir(OP_BYPASS);
    scan_master_model_i.pulse_reset();
    scan(1'b0, 32, '0, got);
    chk_vec(got, ID_VEC, ID_MASK);
    $display("test logic reset done");
    end_sim();
  end
endmodule
